// [pkg/atm_defines.svh]
`ifndef ATM_DEFINES_SVH
`define ATM_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ATM_CFG_ADDR 20'hfff32
`define ATM_CFG_RESET 8'h00
`define ATM_CFG_WMASK 8'he3

// ----------------------------------------------------------------
// Field positions of trigger_mode_config_reg
// ----------------------------------------------------------------
`define ATM_TMODE_HI_POS 7
`define ATM_TMODE_LO_POS 6
`define ATM_ONESHOT_POS 5
`define ATM_TSRC_HI_POS 1
`define ATM_TSRC_LO_POS 0

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define ATM_TMODE_SW 2'h0
`define ATM_TMODE_HW_NOWAIT 2'h2
`define ATM_TMODE_HW_WAIT 2'h3
`define ATM_TSRC_TIMER 2'h0
`define ATM_TSRC_ELC 2'h1
`define ATM_TSRC_INTERVAL 2'h3

// ----------------------------------------------------------------
// Timing count in system-clock cycles and the system-clock period in ns
// ----------------------------------------------------------------
`define ATM_BLANK_CYC 3'h4
`define ATM_SYSCLK_PERIOD_NS 20

`endif

// [pkg/atm_pkg.sv]
package atm_pkg;

    // CPU access to the register space
    typedef struct packed {
        logic [19:0] addr;
        logic wr;
        logic bit_wr;
        logic rd;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } atm_cpu_req_type;

    // Loose converter-mode bits kept outside this block
    typedef struct packed {
        logic run;
        logic [2:0] clk_div_sel;
        logic [1:0] volt_mode;
    } atm_conv_ctrl_type;

    // Hardware trigger sources
    typedef struct packed {
        logic timer_ch1_irq;
        logic elc_event;
        logic interval_timer_irq;
        logic rtc_irq;
    } atm_trig_src_type;

    typedef enum logic [2:0] {
        ATM_IDLE = 3'b001,
        ATM_STAB = 3'b010,
        ATM_CONV = 3'b100
    } atm_state_type;

endpackage

// [design/atm_conv_clk_div.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Conversion clock tick generator
// ----------------------------------------------------------------
module atm_conv_clk_div #(
    parameter int DIV_W = 7
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic restart_in,
    input wire logic [DIV_W-1:0] divisor_in,
    output logic tick_out
);
    logic [DIV_W-1:0] cnt_q;

    always_ff @(posedge clk_in) begin
        if (!resetn_in || restart_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (cnt_q >= divisor_in - DIV_W'(1)) begin
            cnt_q <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + DIV_W'(1);
            tick_out <= 1'b0;
        end
    end
endmodule

// [design/atm_trigger_ctrl.sv]
`timescale 1ns/100ps
`include "atm_defines.svh"

// Behaviour
// - Trigger mode 10 starts a conversion straight on a detected hardware trigger with no wait.
// - Trigger mode 11 runs a stabilization wait after each hardware trigger before converting.
// - Trigger mode 00 starts conversions only from the software run control.
// - The mode bit at 0 gives back-to-back conversions, at 1 a single conversion per start.
// - Source 00 is the timer channel 1 interrupt, 01 the event link event, 10 selects no trigger.
// - Source 11 routes the interval timer interrupt in as the hardware trigger.
// - After an RTC or interval timer trigger, further ones from those are ignored for four clocks.
// - In wait mode the counted conversion duration includes the stabilization interval.
// - Reset clears the configuration register to zero, giving software, sequential, source 00.
// - The configuration register accepts both single-bit and full byte writes.
module atm_trigger_ctrl
    import atm_pkg::*;
#(
    parameter int CONV_CYC_NORMAL1 = 19,
    parameter int CONV_CYC_NORMAL2 = 17,
    parameter int CONV_CYC_LOWV1 = 19,
    parameter int CONV_CYC_LOWV2 = 17,
    parameter int STAB_CYC = 8,
    parameter int CNT_W = 8
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire atm_pkg::atm_cpu_req_type cpu_req_in,
    input wire atm_pkg::atm_conv_ctrl_type conv_ctrl_in,
    input wire atm_pkg::atm_trig_src_type trig_src_in,
    output logic [7:0] rd_data_out,
    output logic conv_busy_out,
    output logic stab_wait_out,
    output logic sample_start_out,
    output logic conv_done_out,
    output logic [CNT_W-1:0] conv_elapsed_out
);
    import atm_pkg::*;

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    logic [7:0] cfg_q;
    logic cfg_hit;
    logic [1:0] trig_mode;
    logic oneshot;
    logic [1:0] trig_src;

    // Writable bits as a named constant so a single bit can be picked out
    localparam logic [7:0] CFG_WMASK = `ATM_CFG_WMASK;

    assign cfg_hit = (cpu_req_in.addr == `ATM_CFG_ADDR);
    assign trig_mode = {cfg_q[`ATM_TMODE_HI_POS], cfg_q[`ATM_TMODE_LO_POS]};
    assign oneshot = cfg_q[`ATM_ONESHOT_POS];
    assign trig_src = {cfg_q[`ATM_TSRC_HI_POS], cfg_q[`ATM_TSRC_LO_POS]};

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cfg_q <= `ATM_CFG_RESET;
        end else if (cfg_hit && cpu_req_in.wr) begin
            cfg_q <= cpu_req_in.wdata & `ATM_CFG_WMASK;
        end else if (cfg_hit && cpu_req_in.bit_wr && CFG_WMASK[cpu_req_in.bit_sel]) begin
            cfg_q[cpu_req_in.bit_sel] <= cpu_req_in.wdata[0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rd_data_out <= 8'h00;
        end else if (cfg_hit && cpu_req_in.rd) begin
            rd_data_out <= cfg_q;
        end else if (cpu_req_in.rd) begin
            rd_data_out <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Hardware trigger selection and blanking
    // ----------------------------------------------------------------
    logic [2:0] blank_q;
    logic blank_src;
    logic raw_trig;
    logic hw_trig;

    // Interval timer and RTC share the short re-trigger blanking
    assign blank_src = (trig_src == `ATM_TSRC_INTERVAL) ? trig_src_in.interval_timer_irq
                                                        : trig_src_in.rtc_irq;

    always_comb begin
        raw_trig = 1'b0;
        if (trig_src == `ATM_TSRC_TIMER) begin
            raw_trig = trig_src_in.timer_ch1_irq;
        end else if (trig_src == `ATM_TSRC_ELC) begin
            raw_trig = trig_src_in.elc_event && !(trig_src_in.rtc_irq && blank_q != 3'h0);
        end else if (trig_src == `ATM_TSRC_INTERVAL) begin
            raw_trig = trig_src_in.interval_timer_irq && (blank_q == 3'h0);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            blank_q <= 3'h0;
        end else if (blank_q != 3'h0) begin
            blank_q <= blank_q - 3'h1;
        end else if (blank_src) begin
            blank_q <= `ATM_BLANK_CYC;
        end
    end

    // Software mode never listens to hardware sources
    assign hw_trig = conv_ctrl_in.run && raw_trig && trig_mode[1];

    // ----------------------------------------------------------------
    // Conversion clock and length
    // ----------------------------------------------------------------
    logic [6:0] divisor;
    logic [CNT_W-1:0] conv_len;
    logic conv_tick;
    logic restart;

    always_comb begin
        case (conv_ctrl_in.clk_div_sel)
            3'h0: divisor = 7'h40;
            3'h1: divisor = 7'h20;
            3'h2: divisor = 7'h10;
            3'h3: divisor = 7'h08;
            3'h4: divisor = 7'h06;
            3'h5: divisor = 7'h05;
            3'h6: divisor = 7'h04;
            default: divisor = 7'h02;
        endcase
    end

    always_comb begin
        case (conv_ctrl_in.volt_mode)
            2'h0: conv_len = CNT_W'(CONV_CYC_NORMAL1);
            2'h1: conv_len = CNT_W'(CONV_CYC_NORMAL2);
            2'h2: conv_len = CNT_W'(CONV_CYC_LOWV1);
            default: conv_len = CNT_W'(CONV_CYC_LOWV2);
        endcase
    end

    atm_conv_clk_div #(
        .DIV_W(7)
    ) u_clk_div (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .restart_in(restart),
        .divisor_in(divisor),
        .tick_out(conv_tick)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    atm_state_type state_q;
    logic run_q;
    logic sw_start;
    logic [CNT_W-1:0] phase_cnt_q;
    logic phase_end;
    logic start_any;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            run_q <= 1'b0;
        end else begin
            run_q <= conv_ctrl_in.run;
        end
    end

    assign sw_start = conv_ctrl_in.run && !run_q && (trig_mode == `ATM_TMODE_SW);
    assign start_any = sw_start || hw_trig;
    assign phase_end = conv_tick && (phase_cnt_q == CNT_W'(1));
    assign restart = (state_q == ATM_IDLE) && start_any;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_q <= ATM_IDLE;
            phase_cnt_q <= '0;
        end else if (!conv_ctrl_in.run) begin
            state_q <= ATM_IDLE;
            phase_cnt_q <= '0;
        end else begin
            case (state_q)
                ATM_IDLE: begin
                    if (hw_trig && trig_mode == `ATM_TMODE_HW_WAIT) begin
                        state_q <= ATM_STAB;
                        phase_cnt_q <= CNT_W'(STAB_CYC);
                    end else if (start_any) begin
                        state_q <= ATM_CONV;
                        phase_cnt_q <= conv_len;
                    end
                end
                ATM_STAB: begin
                    if (phase_end) begin
                        state_q <= ATM_CONV;
                        phase_cnt_q <= conv_len;
                    end else if (conv_tick) begin
                        phase_cnt_q <= phase_cnt_q - CNT_W'(1);
                    end
                end
                ATM_CONV: begin
                    if (phase_end && !oneshot) begin
                        phase_cnt_q <= conv_len;
                    end else if (phase_end) begin
                        state_q <= ATM_IDLE;
                        phase_cnt_q <= '0;
                    end else if (conv_tick) begin
                        phase_cnt_q <= phase_cnt_q - CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= ATM_IDLE;
                    phase_cnt_q <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sample_start_out <= 1'b0;
            conv_done_out <= 1'b0;
        end else begin
            sample_start_out <= conv_ctrl_in.run
                && ((state_q == ATM_IDLE && start_any && !(hw_trig && trig_mode == `ATM_TMODE_HW_WAIT))
                || (state_q == ATM_STAB && phase_end)
                || (state_q == ATM_CONV && phase_end && !oneshot));
            conv_done_out <= conv_ctrl_in.run && state_q == ATM_CONV && phase_end;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            conv_busy_out <= 1'b0;
            stab_wait_out <= 1'b0;
        end else begin
            conv_busy_out <= conv_ctrl_in.run && (state_q != ATM_IDLE || start_any);
            stab_wait_out <= conv_ctrl_in.run
                && ((state_q == ATM_STAB && !phase_end)
                || (state_q == ATM_IDLE && hw_trig && trig_mode == `ATM_TMODE_HW_WAIT));
        end
    end

    // Duration in conversion clocks since the trigger, wait included
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            conv_elapsed_out <= '0;
        end else if (restart) begin
            conv_elapsed_out <= '0;
        end else if (state_q != ATM_IDLE && conv_tick) begin
            conv_elapsed_out <= conv_elapsed_out + CNT_W'(1);
        end
    end
endmodule

// [sim/atm_checker_sva.sv]
`timescale 1ns/100ps
`include "atm_defines.svh"
module atm_checker_sva
    import atm_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire atm_pkg::atm_cpu_req_type cpu_req_in,
    input wire atm_pkg::atm_conv_ctrl_type conv_ctrl_in,
    input wire logic [7:0] rd_data_out,
    input wire logic conv_busy_out,
    input wire logic stab_wait_out,
    input wire logic sample_start_out,
    input wire logic conv_done_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    rst_clear_a: assert property ($rose(resetn_in) |-> rd_data_out == 8'h00 && !conv_busy_out)
        else $error("outputs not clear after reset");
    rsv_zero_a: assert property (cpu_req_in.rd && cpu_req_in.addr == `ATM_CFG_ADDR |=> rd_data_out[4:2] == 3'h0)
        else $error("reserved bits read nonzero");
    unmap_zero_a: assert property (cpu_req_in.rd && cpu_req_in.addr != `ATM_CFG_ADDR |=> rd_data_out == 8'h00)
        else $error("unmapped read nonzero");
    start_kind_a: assert property ($rose(conv_busy_out) |-> sample_start_out != stab_wait_out)
        else $error("start is neither sample nor wait");
    stab_quiet_a: assert property (stab_wait_out |-> !sample_start_out && !conv_done_out)
        else $error("sampling during stabilization wait");
    run_abort_a: assert property (!conv_ctrl_in.run |=> !conv_busy_out)
        else $error("busy while run is low");
    done_gap_a: assert property (sample_start_out |=> !conv_done_out [*3])
        else $error("conversion ended too early");
    done_pulse_a: assert property (conv_done_out |=> !conv_done_out)
        else $error("done longer than one cycle");
endmodule

bind atm_trigger_ctrl atm_checker_sva chk_i (.clk_in(clk_in), .resetn_in(resetn_in), .cpu_req_in(cpu_req_in),
    .conv_ctrl_in(conv_ctrl_in), .rd_data_out(rd_data_out), .conv_busy_out(conv_busy_out),
    .stab_wait_out(stab_wait_out), .sample_start_out(sample_start_out), .conv_done_out(conv_done_out));

// [sim/atm_trig_model.sv]
`timescale 1ns/100ps
module atm_trig_model
    import atm_pkg::*;
(
    input wire logic clk_in,
    input wire logic [3:0] fire_in,
    output atm_pkg::atm_trig_src_type trig_out
);
    logic [3:0] pend_q;

    initial trig_out = '0;
    always @(posedge clk_in) begin
        pend_q <= fire_in;
    end
    // One-cycle pulses, launched off the sampling edge
    always @(negedge clk_in) begin
        trig_out <= atm_trig_src_type'(pend_q);
    end
endmodule

// [sim/test_adc_trigger_mode_control.sv]
`timescale 1ns/100ps
`include "atm_defines.svh"
module test_adc_trigger_mode_control;
    import atm_pkg::*;
    localparam logic [19:0] A = `ATM_CFG_ADDR;
    logic clk, rstn, busy, stab, ss, done, rd_seen, pb;
    logic [7:0] rdat;
    logic [7:0] el;
    logic [3:0] fire;
    logic [31:0] r;
    atm_cpu_req_type req;
    atm_conv_ctrl_type cc;
    atm_trig_src_type trig;
    int n_errors, compares, n_done, n_ss, cnt, k, s0;
    int dv[8] = '{64, 32, 16, 8, 6, 5, 4, 2};
    int ln[4] = '{3, 2, 4, 2};
    int exp_dur[$];
    int exp_el[$];
    logic [7:0] exp_rd[$];

    atm_trigger_ctrl #(.CONV_CYC_NORMAL1(3), .CONV_CYC_NORMAL2(2), .CONV_CYC_LOWV1(4), .CONV_CYC_LOWV2(2),
        .STAB_CYC(2)) uut (.clk_in(clk), .resetn_in(rstn), .cpu_req_in(req), .conv_ctrl_in(cc),
        .trig_src_in(trig), .rd_data_out(rdat), .conv_busy_out(busy), .stab_wait_out(stab),
        .sample_start_out(ss), .conv_done_out(done), .conv_elapsed_out(el));
    atm_trig_model src (.clk_in(clk), .fire_in(fire), .trig_out(trig));

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    always @(posedge clk) begin
        rd_seen <= req.rd;
    end
    always @(negedge clk) begin
        if (rd_seen === 1'b1 && exp_rd.size() > 0) chk("rd_data", exp_rd.pop_front(), rdat);
        cnt = (busy === 1'b1 && pb !== 1'b1) ? 0 : cnt + 1;
        pb = busy;
        n_ss += (ss === 1'b1);
        if (done === 1'b1) begin
            n_done++;
            if (exp_dur.size() > 0) chk("duration", exp_dur.pop_front(), 16'(cnt));
            if (exp_el.size() > 0) chk("elapsed", 16'(exp_el.pop_front()), {8'h0, el});
        end
    end

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
        #1;
    endtask
    task automatic acc(input logic [2:0] wbr, input logic [19:0] a, input logic [7:0] d, input logic [2:0] s);
        req = '{a, wbr[2], wbr[1], wbr[0], s, d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        acc(3'h1, a, 8'h00, 3'h0);
    endtask
    task automatic wt(input int kk);
        for (int i = 0; i < 3000 && n_done < kk; i++) cyc(1);
        chk("done_seen", 16'h1, 16'(n_done >= kk));
    endtask
    task automatic sw(input logic [2:0] c, input logic [1:0] v);
        cc.run = 1'b0;
        cyc(1);
        cc = '{1'b0, c, v};
        cyc(1);
        k = n_done + 1;
        // Done lands one cycle after the last divider tick, one full divisor span per tick
        exp_dur.push_back(dv[c] * ln[v] + 1);
        exp_el.push_back(ln[v]);
        cc.run = 1'b1;
        wt(k);
        cyc(1);
        chk("busy", 16'h0, {15'h0, busy});
    endtask
    task automatic hw(input logic [7:0] g, input logic [3:0] f, input int e);
        cc.run = 1'b0;
        cyc(1);
        acc(3'h4, A, g, 3'h0);
        cc.run = 1'b1;
        cyc(10);
        s0 = n_ss;
        k = n_done + 1;
        // Argument e is the number of conversion ticks, wait included
        if (e > 0) begin
            exp_dur.push_back(dv[cc.clk_div_sel] * e + 1);
            exp_el.push_back(e);
        end
        fire = f;
        cyc(1);
        fire = 4'h0;
        if (e > 0) wt(k);
        else cyc(30);
        chk("starts", 16'(s0 + (e > 0)), 16'(n_ss));
    endtask

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        end_of_test;
    end

    initial begin
        req = '0;
        cc = '0;
        fire = '0;
        rstn = 0;
        pb = 0;
        rd_seen = 0;
        r = 32'h950e;
        cyc(3);
        rstn = 1;
        rd(A, 8'h00);
        r = lfsr(r);
        acc(3'h4, A, r[7:0], 3'h0);
        rd(A, r[7:0] & 8'he3);
        acc(3'h4, A, 8'hff, 3'h0);
        acc(3'h2, A, 8'h00, 3'h7);
        acc(3'h2, A, 8'h01, 3'h3);
        rd(A, 8'h63);
        r = lfsr(r);
        rd({4'h0, r[15:0]}, 8'h00);
        acc(3'h4, A, 8'h20, 3'h0);
        for (int c = 0; c < 8; c++) sw(3'(c), 2'h0);
        for (int v = 0; v < 4; v++) sw(3'h7, 2'(v));
        hw(8'ha0, 4'h8, 2);
        hw(8'ha1, 4'h4, 2);
        hw(8'ha3, 4'h2, 2);
        hw(8'ha0, 4'h7, 0);
        hw(8'ha2, 4'hf, 0);
        hw(8'h20, 4'hf, 0);
        hw(8'he0, 4'h8, 4);
        hw(8'ha3, 4'h0, 0);
        s0 = n_ss;
        fire = 4'h2;
        cyc(1);
        fire = 4'h0;
        cyc(1);
        cc.run = 1'b0;
        cyc(1);
        cc.run = 1'b1;
        fire = 4'h2;
        cyc(1);
        fire = 4'h0;
        cyc(10);
        chk("blank", 16'(s0 + 1), 16'(n_ss));
        cc.run = 1'b0;
        cyc(1);
        acc(3'h4, A, 8'h00, 3'h0);
        k = n_done + 2;
        cc.run = 1'b1;
        cyc(60);
        chk("seq_done", 16'h1, 16'(n_done >= k));
        chk("seq_busy", 16'h1, {15'h0, busy});
        end_of_test;
    end
endmodule
